/* rtl/pss_pkg.sv */
package pss_pkg;

  // array geometry: 512K words of four 9-bit lanes
  localparam int ADDR_W      = 19;
  localparam int LANES       = 4;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W      = LANE_DATA_W + 1;
  localparam int DATA_W      = LANES * LANE_DATA_W;
  localparam int WORD_W      = LANES * LANE_W;
  localparam int DEPTH       = 1 << ADDR_W;

  // burst counter steps the two low address bits, four beats
  localparam int BURST_W     = 2;
  localparam int BURST_BEATS = 4;

  // address and control reach the data bus this many edges later
  localparam int PIPE_DEPTH  = 2;

  localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;

  typedef enum logic [1:0]
  {
    PSS_OP_NONE  = 2'b00,
    PSS_OP_READ  = 2'b01,
    PSS_OP_WRITE = 2'b10
  } pss_op_t;

  // one access travelling down the pipeline
  typedef struct packed
  {
    pss_op_t            op;
    logic [ADDR_W-1:0]  addr;
    logic [LANES-1:0]   lanes;
  } pss_stage_t;

  typedef struct packed
  {
    logic               burst_active;
    logic               burst_write;
    logic [ADDR_W-1:0]  base;
    logic [BURST_W-1:0] count;
    pss_stage_t         p1;
    pss_stage_t         p2;
    logic               drive;
    logic [DATA_W-1:0]  dout;
    logic [LANES-1:0]   pout;
  } pss_state_t;

  localparam pss_stage_t STAGE_IDLE = '{op: PSS_OP_NONE, addr: '0, lanes: LANES_NONE};
  localparam pss_state_t STATE_RST  = '0;

endpackage

/* rtl/pss_array.sv */
`timescale 1ns/1ps
module pss_array
(
  // clock
  input  wire logic                          clk,
  // write side
  input  wire logic                          wr_en,
  input  wire logic [pss_pkg::ADDR_W-1:0]    wr_addr,
  input  wire logic [pss_pkg::LANES-1:0]     wr_lanes,
  input  wire logic [pss_pkg::WORD_W-1:0]    wr_data,
  // read side, combinational
  input  wire logic [pss_pkg::ADDR_W-1:0]    rd_addr,
  output logic      [pss_pkg::WORD_W-1:0]    rd_data
);

  // one storage column per 9-bit lane so that lanes write independently
  for (genvar i = 0; i < pss_pkg::LANES; i++)
  begin : g_lane
    logic [pss_pkg::LANE_W-1:0] mem [pss_pkg::DEPTH];

    always_ff @(posedge clk)
    begin
      if (wr_en && wr_lanes[i])
      begin
        mem[wr_addr] <= wr_data[i*pss_pkg::LANE_W +: pss_pkg::LANE_W];
      end
    end

    assign rd_data[i*pss_pkg::LANE_W +: pss_pkg::LANE_W] = mem[rd_addr];
  end

endmodule // pss_array

/* rtl/pss_sram.sv */
`timescale 1ns/1ps
module pss_sram
(
  // clock and reset
  input  wire logic                             MCLK,
  input  wire logic                             RST,
  // control inputs
  input  wire logic                             CLOCK_GATE_N,
  input  wire logic                             ADVANCE_OR_LOAD,
  input  wire logic                             READ_NOT_WRITE,
  input  wire logic [pss_pkg::LANES-1:0]        BYTE_LANE_WRITE_N,
  input  wire logic                             SELECT_LOW_A,
  input  wire logic                             SELECT_LOW_B,
  input  wire logic                             SELECT_HIGH,
  input  wire logic                             BURST_ORDER_SELECT,
  input  wire logic                             SLEEP_REQUEST,
  input  wire logic                             OUTPUT_ENABLE_N,
  // address
  input  wire logic [pss_pkg::ADDR_W-1:0]       MEM_ADDR,
  // data bus, split into input, output and enable
  input  wire logic [pss_pkg::DATA_W-1:0]       DATA_LANES_IN,
  input  wire logic [pss_pkg::LANES-1:0]        PARITY_LANES_IN,
  output logic      [pss_pkg::DATA_W-1:0]       DATA_LANES_OUT,
  output logic      [pss_pkg::LANES-1:0]        PARITY_LANES_OUT,
  output logic                                  DATA_OE
);

  pss_pkg::pss_state_t          st;
  pss_pkg::pss_state_t          next_st;
  logic                         run;
  logic                         selected;
  logic                         wr_en;
  logic                         fwd;
  logic [pss_pkg::WORD_W-1:0]   wr_word;
  logic [pss_pkg::WORD_W-1:0]   rd_word;
  logic [pss_pkg::DATA_W-1:0]   rd_data;
  logic [pss_pkg::LANES-1:0]    rd_parity;

  // low two address bits for a given beat of the burst
  function automatic logic [pss_pkg::BURST_W-1:0] beat_low
  (
    input logic [pss_pkg::BURST_W-1:0] start,
    input logic [pss_pkg::BURST_W-1:0] count,
    input logic                        interleaved
  );
    logic [pss_pkg::BURST_W-1:0] res;
    if (interleaved)
    begin
      res = start ^ count;
    end
    else
    begin
      res = pss_pkg::BURST_W'(start + count);
    end
    return res;
  endfunction

  // an edge counts only with the gate low and no sleep
  assign run      = !CLOCK_GATE_N && !SLEEP_REQUEST;
  assign selected = !SELECT_LOW_A && !SELECT_LOW_B && SELECT_HIGH;

  // lane i carries data bits 8i..8i+7 plus parity bit i
  for (genvar i = 0; i < pss_pkg::LANES; i++)
  begin : g_lane_map
    assign wr_word[i*pss_pkg::LANE_W +: pss_pkg::LANE_W] =
      {PARITY_LANES_IN[i], DATA_LANES_IN[i*pss_pkg::LANE_DATA_W +: pss_pkg::LANE_DATA_W]};
    assign rd_data[i*pss_pkg::LANE_DATA_W +: pss_pkg::LANE_DATA_W] =
      (fwd && st.p2.lanes[i])
      ? DATA_LANES_IN[i*pss_pkg::LANE_DATA_W +: pss_pkg::LANE_DATA_W]
      : rd_word[i*pss_pkg::LANE_W +: pss_pkg::LANE_DATA_W];
    assign rd_parity[i] = (fwd && st.p2.lanes[i])
                          ? PARITY_LANES_IN[i]
                          : rd_word[i*pss_pkg::LANE_W + pss_pkg::LANE_DATA_W];
  end

  // write data is taken off the bus at the data-phase edge itself
  assign wr_en = run && (st.p2.op == pss_pkg::PSS_OP_WRITE);

  // a write landing on this edge at the word being read is passed through lane by lane
  assign fwd = wr_en && (st.p2.addr == st.p1.addr);

  pss_array u_array
  (
    .clk      (MCLK),
    .wr_en    (wr_en),
    .wr_addr  (st.p2.addr),
    .wr_lanes (st.p2.lanes),
    .wr_data  (wr_word),
    .rd_addr  (st.p1.addr),
    .rd_data  (rd_word)
  );

  always_comb
  begin
    next_st = st;
    if (run)
    begin
      // pending accesses move on whatever the new cycle is
      next_st.p2 = st.p1;
      next_st.p1 = pss_pkg::STAGE_IDLE;
      if (!ADVANCE_OR_LOAD)
      begin
        if (selected)
        begin
          next_st.burst_active = 1'b1;
          next_st.burst_write  = !READ_NOT_WRITE;
          next_st.base         = MEM_ADDR;
          next_st.count        = '0;
          next_st.p1.addr      = MEM_ADDR;
          if (READ_NOT_WRITE)
          begin
            next_st.p1.op    = pss_pkg::PSS_OP_READ;
            next_st.p1.lanes = pss_pkg::LANES_NONE;
          end
          else
          begin
            next_st.p1.op    = pss_pkg::PSS_OP_WRITE;
            next_st.p1.lanes = ~BYTE_LANE_WRITE_N;
          end
        end
        else
        begin
          next_st.burst_active = 1'b0;
        end
      end
      else if (st.burst_active)
      begin
        // address pins are not looked at; count wraps after four beats
        next_st.count   = pss_pkg::BURST_W'(st.count + pss_pkg::COUNT_STEP);
        next_st.p1.addr = {st.base[pss_pkg::ADDR_W-1:pss_pkg::BURST_W],
                           beat_low(st.base[pss_pkg::BURST_W-1:0], next_st.count,
                                    BURST_ORDER_SELECT)};
        if (st.burst_write)
        begin
          next_st.p1.op    = pss_pkg::PSS_OP_WRITE;
          next_st.p1.lanes = ~BYTE_LANE_WRITE_N;
        end
        else
        begin
          next_st.p1.op    = pss_pkg::PSS_OP_READ;
          next_st.p1.lanes = pss_pkg::LANES_NONE;
        end
      end
      // advance with no burst open leaves p1 idle
      // output register: read data stands in the same slot where write data is taken,
      // so a read followed by a write never fights the controller on the bus
      unique case (st.p1.op)
        pss_pkg::PSS_OP_READ:
        begin
          next_st.drive = 1'b1;
          next_st.dout  = rd_data;
          next_st.pout  = rd_parity;
        end
        pss_pkg::PSS_OP_WRITE,
        pss_pkg::PSS_OP_NONE:
        begin
          next_st.drive = 1'b0;
        end
        default:
        begin
          next_st.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      st <= pss_pkg::STATE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign DATA_LANES_OUT   = st.dout;
  assign PARITY_LANES_OUT = st.pout;
  assign DATA_OE          = st.drive && !OUTPUT_ENABLE_N;

  // read data is registered on the next active edge and sampled on the one after
  property p_read_latency;
    @(posedge MCLK) disable iff (RST)
    (run && !ADVANCE_OR_LOAD && selected && READ_NOT_WRITE) ##1 run
      |=> st.drive;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read data not driven two cycles after load");

  property p_write_float;
    @(posedge MCLK) disable iff (RST)
    (run && !ADVANCE_OR_LOAD && selected && !READ_NOT_WRITE) ##1 run
      |=> !st.drive;
  endproperty
  a_write_float: assert property (p_write_float)
    else $error("bus driven during write data phase");

  property p_deselect_float;
    @(posedge MCLK) disable iff (RST)
    (run && !ADVANCE_OR_LOAD && !selected) ##1 run |=> !DATA_OE;
  endproperty
  a_deselect_float: assert property (p_deselect_float)
    else $error("bus driven two cycles after deselect");

  property p_suspend_hold;
    @(posedge MCLK) disable iff (RST)
    !run |=> $stable(st);
  endproperty
  a_suspend_hold: assert property (p_suspend_hold)
    else $error("state changed on a suspended edge");

  property p_no_start_deselected;
    @(posedge MCLK) disable iff (RST)
    (run && !ADVANCE_OR_LOAD && !selected)
      |=> (st.p1.op == pss_pkg::PSS_OP_NONE) && !st.burst_active;
  endproperty
  a_no_start_deselected: assert property (p_no_start_deselected)
    else $error("access started or burst kept while deselected");

  property p_load_capture;
    @(posedge MCLK) disable iff (RST)
    (run && !ADVANCE_OR_LOAD && selected)
      |=> (st.p1.addr == $past(MEM_ADDR)) && (st.p1.op != pss_pkg::PSS_OP_NONE);
  endproperty
  a_load_capture: assert property (p_load_capture)
    else $error("selected load did not capture address");

  property p_pending_complete;
    @(posedge MCLK) disable iff (RST)
    (run && (st.p1.op == pss_pkg::PSS_OP_READ)) |=> st.drive;
  endproperty
  a_pending_complete: assert property (p_pending_complete)
    else $error("pending read lost");

  property p_counter_step;
    @(posedge MCLK) disable iff (RST)
    (run && ADVANCE_OR_LOAD && st.burst_active)
      |=> st.count == pss_pkg::BURST_W'($past(st.count) + pss_pkg::COUNT_STEP);
  endproperty
  a_counter_step: assert property (p_counter_step)
    else $error("burst counter did not advance");

  property p_burst_upper;
    @(posedge MCLK) disable iff (RST)
    (run && ADVANCE_OR_LOAD && st.burst_active)
      |=> st.p1.addr[pss_pkg::ADDR_W-1:pss_pkg::BURST_W]
          == st.base[pss_pkg::ADDR_W-1:pss_pkg::BURST_W];
  endproperty
  a_burst_upper: assert property (p_burst_upper)
    else $error("burst changed upper address bits");

  property p_burst_kind;
    @(posedge MCLK) disable iff (RST)
    (run && ADVANCE_OR_LOAD && st.burst_active)
      |=> (st.p1.op == pss_pkg::PSS_OP_WRITE) == $past(st.burst_write);
  endproperty
  a_burst_kind: assert property (p_burst_kind)
    else $error("burst beat kind differs from load");

  property p_interleave;
    @(posedge MCLK) disable iff (RST)
    (run && ADVANCE_OR_LOAD && st.burst_active && BURST_ORDER_SELECT)
      |=> st.p1.addr[pss_pkg::BURST_W-1:0] == (st.base[pss_pkg::BURST_W-1:0] ^ st.count);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved burst address wrong");

  property p_idle_advance;
    @(posedge MCLK) disable iff (RST)
    (run && ADVANCE_OR_LOAD && !st.burst_active) ##1 run |=> !st.drive;
  endproperty
  a_idle_advance: assert property (p_idle_advance)
    else $error("advance after deselect drove the bus");

  property p_oe_async;
    @(posedge MCLK) disable iff (RST)
    OUTPUT_ENABLE_N |-> !DATA_OE;
  endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("bus driven with output enable high");

  property p_read_lanes;
    @(posedge MCLK) disable iff (RST)
    (run && !ADVANCE_OR_LOAD && selected && READ_NOT_WRITE)
      |=> st.p1.lanes == pss_pkg::LANES_NONE;
  endproperty
  a_read_lanes: assert property (p_read_lanes)
    else $error("lane enables kept on a read");

endmodule // pss_sram

/* sim/pss_ctrl_model.sv */
`timescale 1ns/1ps
module pss_ctrl_model
(
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // run qualifier and write beat request
  input  wire logic                        run,
  input  wire logic                        wr_now,
  input  wire logic [pss_pkg::WORD_W-1:0]  wr_word,
  // device side of the shared bus
  input  wire logic                        dev_oe,
  input  wire logic [pss_pkg::WORD_W-1:0]  dev_word,
  output logic      [pss_pkg::WORD_W-1:0]  bus
);
  logic                       s1_wr;
  logic                       s2_wr;
  logic [pss_pkg::WORD_W-1:0] s1_d;
  logic [pss_pkg::WORD_W-1:0] s2_d;
  logic [pss_pkg::WORD_W-1:0] last = '0;

  // write data goes on the bus two run edges after its beat
  always @(posedge mclk)
  begin
    last <= bus;
    if (rst)
    begin
      s1_wr <= 1'b0;
      s2_wr <= 1'b0;
    end
    else if (run)
    begin
      s1_wr <= wr_now;
      s1_d  <= wr_word;
      s2_wr <= s1_wr;
      s2_d  <= s1_d;
    end
  end

  // nobody driving: show the inverse of the last level
  assign bus = dev_oe ? dev_word : (s2_wr ? s2_d : ~last);
endmodule // pss_ctrl_model

/* sim/pipelined_sync_sram_burst_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module pipelined_sync_sram_burst_tb;
  typedef struct {int op; logic [18:0] ad; logic [3:0] ln; logic [35:0] wd;} pss_slot_t;
  logic        MCLK = 0, RST = 1, gate_n = 0, adv = 0, rnw = 1, order = 0, sleep = 0;
  logic        oe_n = 0, wr_now = 0, oe, exp_drive = 0, b_on = 0, b_wr;
  logic [3:0]  bw_n = '1, pout, lm;
  logic [2:0]  sel = 3'b000;
  logic [18:0] addr = '0, b_base;
  logic [1:0]  b_k;
  logic [35:0] wword = '0, bus, exp_word, m;
  logic [31:0] dout;
  logic [35:0] mem [int];
  pss_slot_t   p1, p2, nw;
  int          failures = 0, n_checks = 0, r, o;

  always #20 MCLK = ~MCLK;

  pss_sram pss_sram_inst (.MCLK(MCLK), .RST(RST), .CLOCK_GATE_N(gate_n),
    .ADVANCE_OR_LOAD(adv), .READ_NOT_WRITE(rnw), .BYTE_LANE_WRITE_N(bw_n),
    .SELECT_LOW_A(sel[2]), .SELECT_LOW_B(sel[1]), .SELECT_HIGH(sel[0]),
    .BURST_ORDER_SELECT(order), .SLEEP_REQUEST(sleep), .OUTPUT_ENABLE_N(oe_n),
    .MEM_ADDR(addr), .DATA_LANES_IN(bus[31:0]), .PARITY_LANES_IN(bus[35:32]),
    .DATA_LANES_OUT(dout), .PARITY_LANES_OUT(pout), .DATA_OE(oe));

  pss_ctrl_model pss_ctrl_model_inst (.mclk(MCLK), .rst(RST), .run(!gate_n && !sleep),
    .wr_now(wr_now), .wr_word(wword), .dev_oe(oe), .dev_word({pout, dout}), .bus(bus));

  task complete_run;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [18:0] pool(input int i);
    return {i[5], 13'h0, i[4:0]};
  endfunction

  task step(input logic g, a, rw, input logic [3:0] bw, input logic [2:0] s,
            input logic [18:0] ad, input logic z, on);
    @(posedge MCLK);
    #1;
    `CHK(oe, exp_drive && !oe_n)
    `CHK(oe && pss_ctrl_model_inst.s2_wr, 1'b0)
    if (exp_drive) `CHK({pout, dout}, exp_word)
    #1;
    gate_n = g; adv = a; rnw = rw; bw_n = bw; sel = s; addr = ad; sleep = z; oe_n = on;
    wword = 36'({$urandom, $urandom});
    wr_now = 0;
    #1;
    `CHK(oe, exp_drive && !oe_n)
    if (!g && !z)
    begin
      nw = '{0, '0, '0, '0};
      if (!a && s == 3'b001)
      begin
        b_on = 1; b_wr = !rw; b_base = ad; b_k = 0; nw.op = rw ? 1 : 2; nw.ad = ad;
      end
      else if (!a)
        b_on = 0;
      else if (b_on)
      begin
        b_k++;
        nw.op = b_wr ? 2 : 1;
        nw.ad = {b_base[18:2], order ? b_base[1:0] ^ b_k : b_base[1:0] + b_k};
      end
      if (nw.op == 2)
      begin
        nw.ln = ~bw; nw.wd = wword; wr_now = 1;
      end
      if (p2.op == 2)
      begin
        m = mem.exists(int'(p2.ad)) ? mem[int'(p2.ad)] : '0;
        for (int i = 0; i < 4; i++)
          if (p2.ln[i])
          begin
            m[8*i+:8] = p2.wd[8*i+:8]; m[32+i] = p2.wd[32+i];
          end
        mem[int'(p2.ad)] = m;
      end
      exp_drive = (p1.op == 1);
      if (exp_drive) exp_word = mem[int'(p1.ad)];
      p2 = p1; p1 = nw;
    end
  endtask

  task do_reset(input logic ord);
    // let pending writes land before the pipeline is cleared
    repeat (2) step(0, 0, 1, 4'h0, 3'b000, '0, 0, 0);
    @(posedge MCLK);
    #2;
    RST = 1; order = ord; adv = 0; sel = 3'b000; wr_now = 0; gate_n = 0; sleep = 0;
    p1 = '{0, '0, '0, '0}; p2 = p1; b_on = 0; exp_drive = 0;
    repeat (8) @(posedge MCLK);
    #2 RST = 0;
    `CHK(oe, 1'b0)
  endtask

  initial
  begin
    #200000 failures++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'hf2876072));
    do_reset(0);
    for (int i = 0; i < 64; i++)
      step(0, 0, 0, 4'h0, 3'b001, pool(i), 0, 0);
    for (o = 0; o < 2; o++)
    begin
      do_reset(o[0]);
      step(0, 0, 1, 4'h0, 3'b001, pool(7), 0, 0);
      repeat (6) step(0, 1, 0, 4'h0, 3'b000, '1, 0, 0);
      for (int n = 0; n < 500; n++)
      begin
        r = $urandom % 8;
        step(r == 6, r > 1 && r < 5, 1'($urandom), 4'($urandom),
             r == 5 ? 3'(1 << ($urandom % 3)) ^ 3'b001
             : (r < 2 ? 3'b001 : 3'($urandom)), pool($urandom % 64), r == 7, $urandom % 6 == 0);
      end
    end
    repeat (3) step(0, 0, 1, 4'h0, 3'b000, '0, 0, 0);
    complete_run;
  end
endmodule // pipelined_sync_sram_burst_tb
